// file: core/iesc_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Reset clears the global interrupt enable bit.
// - Accept only when global enable, source enable and mask level all pass.
// - Disable instruction clears global enable, enable instruction sets it.
// - Global enable also writable as bit 0 of processor status one.
// - Interrupt processing starts only when all acceptance conditions hold together.
// - Low enable register: bits 7,6,4,3,0; other bits written zero.
// - High enable register: bits 6,4,2; other bits written zero.
// - Low request register read/write, flags at 7,6,4,3,0, zeros elsewhere.
// - High request register read/write, flags at 6,4,2, zeros elsewhere.
// - Standby ends when an enabled request becomes pending.
// - HALT instruction enters HALT, STOP instruction enters STOP; fetch stops.
// - Standby left by reset or qualifying interrupt; STOP restricts sources.
// - HALT keeps clocks running; wakes immediately from any maskable source.
// - STOP halts main clock; main-clock blocks cannot wake the device.
// - In STOP main-clock timer stops; external-clock timer may still interrupt.
// - Only timer 1, clock timer and serial interrupts wake from STOP.
// - In STOP the sampled external pin input is ignored for wake-up.
// - STOP wake-up runs the oscillator warm-up before execution resumes.
// - Standby preserves registers; running blocks may still set request flags.
// - Port direction and output levels are held during standby.
// - STOP instruction clock-change use is kept apart from STOP standby.
// - Mask 000/001 admit all levels; each higher code drops one more.
// - Simultaneous requests served DMA first down to parallel port last.
// - Warm-up lasts about 2^18 main-clock cycles, device stays halted.

module iesc_top
  import iesc_pkg::*;
#(
  parameter int WARMUP = WARMUP_CYCLES,
  parameter int WARM_W = 19
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // CPU core instruction strobes
  input  wire logic        enable_irq_instr,
  input  wire logic        disable_irq_instr,
  input  wire logic        halt_instr,
  input  wire logic        stop_instr,
  input  wire logic        clock_change_sel,
  input  wire logic        status_one_we,
  input  wire logic        status_one_bit,
  input  wire logic [2:0]  priority_mask_field,
  input  wire logic        irq_ack,
  // Peripheral request events, one bit per source in priority order
  input  wire logic [7:0]  src_event,
  // CPU core status
  output var  logic        global_enable,
  output var  logic        irq_req,
  output var  logic [2:0]  irq_id,
  output var  logic        cpu_stalled,
  output var  logic        main_clk_run,
  output var  logic        clock_change_req,
  output var  logic        port_hold
);

  // ******************************
  // Helpers
  // ******************************

  // Map 8-source vector onto the two register layouts
  function automatic logic [15:0] to_regs(input logic [7:0] s);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = {s[SRC_DMA], s[SRC_TIMER0], 1'b0, s[SRC_EXT], s[SRC_UART], 2'b00, s[SRC_DISPLAY]};
    hi = {1'b0, s[SRC_TIMER1], 1'b0, s[SRC_CLOCK], 1'b0, s[SRC_PARPORT], 2'b00};
    return {hi, lo};
  endfunction

  function automatic logic [7:0] from_regs(input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] s;
    s = '0;
    s[SRC_DMA]     = lo[7];
    s[SRC_TIMER0]  = lo[6];
    s[SRC_EXT]     = lo[4];
    s[SRC_UART]    = lo[3];
    s[SRC_DISPLAY] = lo[0];
    s[SRC_TIMER1]  = hi[6];
    s[SRC_CLOCK]   = hi[4];
    s[SRC_PARPORT] = hi[2];
    return s;
  endfunction

  // ******************************
  // Registers and state
  // ******************************
  logic [7:0]  en_low_q;
  logic [7:0]  en_high_q;
  logic [7:0]  req_low_q;
  logic [7:0]  req_high_q;
  iesc_state_t state_q;
  logic        warm_start;
  logic        warm_done;

  // Bus request decode
  logic        wb_req;
  logic        wr_en_low;
  logic        wr_en_high;
  logic        wr_req_low;
  logic        wr_req_high;
  logic [7:0]  wdata;

  assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wdata       = wb_dat_i[7:0];
  assign wr_en_low   = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_EN_LOW);
  assign wr_en_high  = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_EN_HIGH);
  assign wr_req_low  = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_REQ_LOW);
  assign wr_req_high = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADDR_REQ_HIGH);

  // ******************************
  // Acceptance logic
  // ******************************
  logic [7:0]  enables;
  logic [7:0]  requests;
  logic [7:0]  level_ok;
  logic [7:0]  candidates;
  logic [7:0]  wake_src;
  logic [7:0]  stop_events;
  logic        any_cand;
  logic [2:0]  win_id;
  logic [15:0] ev_regs;
  logic [15:0] clr_regs;
  logic [7:0]  accept_vec;

  assign enables  = from_regs(en_low_q, en_high_q);
  assign requests = from_regs(req_low_q, req_high_q);

  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_level
      assign level_ok[i] = (priority_mask_field <= 3'h1) || (i < (9 - int'(priority_mask_field)));
    end
  endgenerate

  assign candidates = (global_enable && state_q == ST_RUN) ? (requests & enables & level_ok) : 8'h00;
  assign any_cand   = |candidates;

  always_comb begin
    win_id = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (candidates[i]) begin
        win_id = 3'(i);
      end
    end
  end

  // STOP filters events: main-clock blocks and sampled pin silent
  assign stop_events = (state_q == ST_STOP || state_q == ST_WARMUP) ? (src_event & STOP_WAKE_MASK) : src_event;
  assign wake_src    = requests & enables;

  // Acknowledge clears only the winning flag
  assign accept_vec = (irq_ack && irq_req) ? (8'h01 << irq_id) : 8'h00;
  assign ev_regs    = to_regs(stop_events);
  assign clr_regs   = to_regs(accept_vec);

  // ******************************
  // Register file
  // ******************************

  // enable registers, unused bits kept zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      en_low_q  <= REG_RESET;
      en_high_q <= REG_RESET;
    end else begin
      if (wr_en_low)  en_low_q  <= wdata & LOW_USED_MASK;
      if (wr_en_high) en_high_q <= wdata & HIGH_USED_MASK;
    end
  end

  // request flags, event set wins over clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_low_q  <= REG_RESET;
      req_high_q <= REG_RESET;
    end else begin
      req_low_q  <= ((wr_req_low ? wdata : req_low_q) & ~clr_regs[7:0]
                     | ev_regs[7:0]) & LOW_USED_MASK;
      req_high_q <= ((wr_req_high ? wdata : req_high_q) & ~clr_regs[15:8]
                     | ev_regs[15:8]) & HIGH_USED_MASK;
    end
  end

  // Bus answer: one-cycle ack, unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          ADDR_EN_LOW:   wb_dat_o <= {24'h000000, en_low_q};
          ADDR_EN_HIGH:  wb_dat_o <= {24'h000000, en_high_q};
          ADDR_REQ_LOW:  wb_dat_o <= {24'h000000, req_low_q};
          ADDR_REQ_HIGH: wb_dat_o <= {24'h000000, req_high_q};
          default:       wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ******************************
  // Global enable
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      global_enable <= 1'b0;
    end else if (disable_irq_instr) begin
      global_enable <= 1'b0;
    end else if (enable_irq_instr) begin
      global_enable <= 1'b1;
    end else if (status_one_we) begin
      global_enable <= status_one_bit;
    end
  end

  // ******************************
  // Standby state machine
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          // standby entry; clock change is not standby
          if (halt_instr) begin
            state_q <= ST_HALT;
          end else if (stop_instr && !clock_change_sel) begin
            state_q <= ST_STOP;
          end
        end
        ST_HALT: begin
          if (|wake_src) state_q <= ST_RUN;
        end
        ST_STOP: begin
          if (|(wake_src & STOP_WAKE_MASK)) state_q <= ST_WARMUP;
        end
        ST_WARMUP: begin
          if (warm_done) state_q <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  assign warm_start = (state_q == ST_STOP) && |(wake_src & STOP_WAKE_MASK);

  iesc_warmup #(
    .WIDTH (WARM_W)
  ) u_warmup (
    .clk_sys (clk_sys),
    .srst    (srst),
    .start   (warm_start),
    .span    (WARM_W'(WARMUP)),
    .done    (warm_done)
  );

  // ******************************
  // Outputs to the core
  // ******************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_req          <= 1'b0;
      irq_id           <= 3'h0;
      cpu_stalled      <= 1'b0;
      main_clk_run     <= 1'b1;
      clock_change_req <= 1'b0;
      port_hold        <= 1'b0;
    end else begin
      irq_req          <= any_cand && !(irq_ack && irq_req);
      irq_id           <= win_id;
      cpu_stalled      <= (state_q != ST_RUN);
      main_clk_run     <= (state_q != ST_STOP);
      clock_change_req <= (state_q == ST_RUN) && stop_instr && clock_change_sel;
      port_hold        <= (state_q != ST_RUN);
    end
  end

endmodule

`default_nettype wire

// file: inc/iesc_pkg.sv
package iesc_pkg;

  // ******************************
  // Register byte addresses
  // ******************************
  localparam logic [3:0] ADDR_EN_LOW   = 4'h0;
  localparam logic [3:0] ADDR_EN_HIGH  = 4'h4;
  localparam logic [3:0] ADDR_REQ_LOW  = 4'h8;
  localparam logic [3:0] ADDR_REQ_HIGH = 4'hC;

  // ******************************
  // Field layouts and reset values
  // ******************************
  localparam logic [7:0] LOW_USED_MASK  = 8'hD9;
  localparam logic [7:0] HIGH_USED_MASK = 8'h54;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [2:0] MASK_RESET     = 3'h0;

  // Source index order is also the fixed priority order
  localparam int NUM_SRC     = 8;
  localparam int SRC_DMA     = 0;
  localparam int SRC_TIMER0  = 1;
  localparam int SRC_EXT     = 2;
  localparam int SRC_UART    = 3;
  localparam int SRC_DISPLAY = 4;
  localparam int SRC_TIMER1  = 5;
  localparam int SRC_CLOCK   = 6;
  localparam int SRC_PARPORT = 7;

  // Sources allowed to wake from STOP: timer 1, clock timer, UART
  localparam logic [7:0] STOP_WAKE_MASK = 8'h68;

  // ******************************
  // Timing
  // ******************************
  localparam int WARMUP_CYCLES = 262144;

  // ******************************
  // Standby states
  // ******************************
  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_HALT   = 4'h2,
    ST_STOP   = 4'h4,
    ST_WARMUP = 4'h8
  } iesc_state_t;

endpackage

// file: core/iesc_warmup.sv
`timescale 1ns/1ps
`default_nettype none

module iesc_warmup #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Control
  input  wire logic start,
  input  wire logic [WIDTH-1:0] span,
  output var  logic done
);

  logic [WIDTH-1:0] count_q;
  logic             busy_q;

  // Counts down one span; done pulses on the final cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q <= '0;
      busy_q  <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= span;
        busy_q  <= 1'b1;
      end else if (busy_q) begin
        if (count_q <= WIDTH'(1)) begin
          busy_q <= 1'b0;
          done   <= 1'b1;
        end else begin
          count_q <= count_q - WIDTH'(1);
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: verif/iesc_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module iesc_chk (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  // Core side
  input  wire logic        enable_irq_instr,
  input  wire logic        disable_irq_instr,
  input  wire logic        halt_instr,
  input  wire logic        stop_instr,
  input  wire logic        clock_change_sel,
  input  wire logic        status_one_we,
  input  wire logic        status_one_bit,
  input  wire logic        global_enable,
  input  wire logic        irq_req,
  input  wire logic        cpu_stalled,
  input  wire logic        clock_change_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_req; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack after request");
  property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
  property p_rst; disable iff (1'b0) srst |=> !global_enable; endproperty
  a_rst: assert property (p_rst) else $error("enable set after reset");
  property p_di; disable_irq_instr |=> !global_enable; endproperty
  a_di: assert property (p_di) else $error("disable did not clear");
  property p_ei; enable_irq_instr && !disable_irq_instr |=> global_enable; endproperty
  a_ei: assert property (p_ei) else $error("enable did not set");
  property p_sw;
    status_one_we && !enable_irq_instr && !disable_irq_instr |=> global_enable == $past(status_one_bit);
  endproperty
  a_sw: assert property (p_sw) else $error("status write lost");
  property p_gate; !global_enable [*2] |-> !irq_req; endproperty
  a_gate: assert property (p_gate) else $error("request while disabled");
  property p_halt; halt_instr && !stop_instr && !cpu_stalled |-> ##2 cpu_stalled; endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_cc; stop_instr && clock_change_sel && !cpu_stalled |-> ##[1:2] clock_change_req; endproperty
  a_cc: assert property (p_cc) else $error("no clock change pulse");
endmodule

bind iesc_top iesc_chk chk_u (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .enable_irq_instr(enable_irq_instr), .disable_irq_instr(disable_irq_instr),
  .halt_instr(halt_instr), .stop_instr(stop_instr), .clock_change_sel(clock_change_sel),
  .status_one_we(status_one_we), .status_one_bit(status_one_bit),
  .global_enable(global_enable), .irq_req(irq_req), .cpu_stalled(cpu_stalled),
  .clock_change_req(clock_change_req));

`default_nettype wire

// file: verif/iesc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module iesc_core_model (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Accept handshake
  input  wire logic ack_en,
  input  wire logic irq_req,
  output var  logic irq_ack
);
  logic [1:0] gap_q;

  always_ff @(posedge clk_sys) begin
    if (srst || !ack_en) begin
      irq_ack <= 1'b0;
      gap_q   <= 2'h0;
    end else if (irq_req && gap_q == 2'h0) begin
      irq_ack <= 1'b1;
      gap_q   <= 2'h3;
    end else begin
      irq_ack <= 1'b0;
      gap_q   <= (gap_q == 2'h0) ? 2'h0 : gap_q - 2'h1;
    end
  end
endmodule

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import iesc_pkg::*;
  logic clk_sys = 0, srst = 1, cyc = 0, stb = 0, we = 0, ei = 0, di = 0, hi = 0, si = 0;
  logic ccs = 0, swe = 0, sb = 0, ack_en = 0, iack, ack, ge, irq, stl, mrun, ccr, ph;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [2:0]  msk = 3'h0, id;
  logic [7:0]  ev = 8'h00, r;
  int          bad_count = 0, checks_done = 0, n;
  logic [19:0] rows [9] = '{20'h0FFD9, 20'h4FF54, 20'h8FFD9, 20'hCFF54, 20'h2FF00,
                            20'h00000, 20'h40000, 20'h80000, 20'hC0000};
  logic [4:0]  ge_rows [6] = '{5'h18, 5'h11, 5'h04, 5'h07, 5'h15, 5'h0C};

  // Clock
  always #4 clk_sys = ~clk_sys;

  iesc_top #(.WARMUP(8)) dut_u (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .enable_irq_instr(ei), .disable_irq_instr(di), .halt_instr(hi), .stop_instr(si),
    .clock_change_sel(ccs), .status_one_we(swe), .status_one_bit(sb), .priority_mask_field(msk),
    .irq_ack(iack), .src_event(ev), .global_enable(ge), .irq_req(irq), .irq_id(id),
    .cpu_stalled(stl), .main_clk_run(mrun), .clock_change_req(ccr), .port_hold(ph));

  iesc_core_model pm_u (.clk_sys(clk_sys), .srst(srst), .ack_en(ack_en), .irq_req(irq), .irq_ack(iack));

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 20);
    // Missing ack counts as a mismatch
    if (ack !== 1'b1) bad_count++;
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic cpu(input logic [5:0] v);
    {ei, di, swe, sb, hi, si} <= v;
    @(posedge clk_sys);
    {ei, di, swe, sb, hi, si} <= 6'h00;
    // Idle edge so a following call never overwrites the drop
    @(posedge clk_sys);
  endtask

  task automatic evp(input logic [7:0] e);
    ev <= e;
    @(posedge clk_sys);
    ev <= 8'h00;
  endtask

  task automatic wait_stl(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (stl !== 1'b0 && n < lim);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    close_out;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, rows[i][19:16], rows[i][15:8]);
      wb(1'b0, rows[i][19:16], 8'h00);
      chk(r, rows[i][7:0]);
    end
    $display("register rows done");
    for (int i = 0; i < 6; i++) begin
      cpu({ge_rows[i][4:1], 2'b00});
      repeat (2) @(posedge clk_sys);
      chk(ge, ge_rows[i][0]);
    end
    $display("global enable done");
    wb(1'b1, ADDR_EN_LOW, LOW_USED_MASK);
    wb(1'b1, ADDR_EN_HIGH, HIGH_USED_MASK);
    cpu(6'h20);
    for (int c = 0; c < 8; c++) begin
      msk <= c[2:0];
      wb(1'b1, ADDR_REQ_HIGH, 8'h04);
      repeat (3) @(posedge clk_sys);
      chk(irq, c < 2);
      wb(1'b1, ADDR_REQ_HIGH, 8'h00);
    end
    $display("mask done");
    msk <= 3'h0;
    cpu(6'h10);
    wb(1'b1, ADDR_REQ_LOW, LOW_USED_MASK);
    wb(1'b1, ADDR_REQ_HIGH, HIGH_USED_MASK);
    repeat (4) @(posedge clk_sys);
    chk(irq, 1'b0);
    ack_en <= 1'b1;
    cpu(6'h20);
    for (int i = 0; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (iack !== 1'b1 && n < 50);
      if (iack !== 1'b1) bad_count++;
      chk({5'h00, id}, i[7:0]);
    end
    ack_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wb(1'b0, ADDR_REQ_LOW, 8'h00);
    chk(r, 8'h00);
    $display("priority done");
    cpu(6'h10);
    cpu(6'h02);
    repeat (4) @(posedge clk_sys);
    chk(stl, 1'b1);
    chk(ph, 1'b1);
    evp(8'h80);
    wait_stl(20);
    chk(n < 20, 1'b1);
    chk(ph, 1'b0);
    wb(1'b0, ADDR_REQ_HIGH, 8'h00);
    chk(r, 8'h04);
    wb(1'b1, ADDR_REQ_HIGH, 8'h00);
    $display("halt done");
    cpu(6'h01);
    chk(ccr, 1'b0);
    repeat (4) @(posedge clk_sys);
    chk(mrun, 1'b0);
    evp(8'h07);
    repeat (4) @(posedge clk_sys);
    chk(stl, 1'b1);
    evp(8'h48);
    wait_stl(100);
    chk(n >= 8 && n < 100, 1'b1);
    chk(mrun, 1'b1);
    wb(1'b0, ADDR_REQ_LOW, 8'h00);
    chk(r, 8'h08);
    wb(1'b0, ADDR_REQ_HIGH, 8'h00);
    chk(r, 8'h10);
    $display("stop done");
    ccs <= 1'b1;
    cpu(6'h01);
    chk(ccr, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk(stl, 1'b0);
    ccs <= 1'b0;
    $display("clock change done");
    cpu(6'h20);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, {i[1:0], 2'b00}, 8'h00);
      chk(r, REG_RESET);
    end
    chk(ge, 1'b0);
    $display("reset done");
    close_out;
  end
endmodule

`default_nettype wire
